// *** irq_ctrl_pkg.sv ***
// Purpose: Shared constants and carriers for the interrupt controller.
// Assumes: One 250 MHz clock, APB register access.
// Notes: Every offset and cycle count lives here, and the reset values of pending, source enable, priority and external config.
package irq_ctrl_pkg;

  // ************************************************************
  // Sizes and timing
  // ************************************************************
  localparam int unsigned NUM_SRC = 16;
  localparam int unsigned CLK_MHZ = 250;
  localparam logic [3:0] DETECT_CYC = 4'h1;
  localparam logic [3:0] CALL_CYC = 4'h4;
  localparam logic [3:0] RETURN_FROM_INTERRUPT_CYC = 4'h5;
  localparam logic [3:0] DIV_CYC = 4'h8;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] OFS_PEND = 12'h000;
  localparam logic [11:0] OFS_ENABLE = 12'h004;
  localparam logic [11:0] OFS_PRIO = 12'h008;
  localparam logic [11:0] OFS_EXTCFG = 12'h00C;
  localparam logic [11:0] OFS_TIMER_CONTROL_REG = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [15:0] RST_PEND = 16'h0000;
  localparam logic [15:0] RST_ENABLE = 16'h0000;
  localparam logic [15:0] RST_PRIO = 16'h0000;
  localparam logic [3:0] RST_EXTCFG = 4'h0;
  localparam int unsigned GIE_BIT = 16;
  localparam int unsigned TIMER_CONTROL_REG_EXT0 = 1;
  localparam int unsigned TIMER_CONTROL_REG_EXT1 = 3;
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_TMR0 = 1;
  localparam int unsigned SRC_EXT1 = 2;
  localparam int unsigned SRC_TMR1 = 3;
  // External config: [0] edge0, [1] pol0, [2] edge1, [3] pol1.
  localparam int unsigned CFG_EDGE0 = 0;
  localparam int unsigned CFG_POL0 = 1;
  localparam int unsigned CFG_EDGE1 = 2;
  localparam int unsigned CFG_POL1 = 3;

  typedef struct packed {
    logic valid;
    logic high;
    logic [3:0] index;
  } req_s;

endpackage : irq_ctrl_pkg

// *** irq_ctrl.sv ***
// Purpose: Sixteen-source two-level interrupt controller with APB access.
// Assumes: Sequencer pulses call_done, return_from_interrupt_done and instr_done itself.
// Notes: A level source must stay active until recognised.
//
// Notes on behaviour
// - Sixteen sources, each with pending flag and fixed entry point.
// - Software setting a pending flag acts like a hardware event, except on an external input in level mode.
// - Per external input: edge bit 1 edge, polarity bit 1 active high.
// - External inputs sample their pin regardless of pin sharing.
// - External pending flags read at bits 1 and 3 of timer control.
// - Edge mode external flag clears when the CPU vectors.
// - Level mode external flag follows the input's active state.
// - One priority bit per source, low after reset.
// - High preempts low service; nothing preempts high service.
// - Higher level first; equal level lowest source number wins.
// - Sampled each clock; fastest response five cycles.
// - After return, one further instruction before the next call.
// - Worst case eighteen cycles via return plus divide.
// - Equal or higher running service blocks new requests until return.
// - Service deferred while the CPU is stalled.
// - Vector is 0x0003 plus eight times source index.
// - Flags set regardless of enable; request needs global and own enable.
// - Flag still set after return raises a new request once the following instruction ends.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module irq_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] src_event,
  input wire logic ext_irq_zero_input,
  input wire logic ext_irq_one_input,
  input wire logic cpu_stall,
  input wire logic instr_done,
  input wire logic call_done,
  input wire logic return_from_interrupt_done,
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [3:0] irq_index
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0] pend_ff;
  logic [15:0] enable_ff;
  logic [15:0] prio_ff;
  logic global_irq_enable_ff;
  logic [3:0] ext_irq_pin_config_ff;
  logic [1:0] ext_prev_ff;
  logic in_low_ff;
  logic in_high_ff;
  logic hold_ff;
  logic [1:0] ext_active;
  logic [1:0] edge_mode;
  logic [15:0] eligible;
  logic [15:0] sw_set;
  logic [15:0] hw_clr;
  logic [15:0] nxt_pend;
  logic [31:0] nxt_prdata;
  irq_ctrl_pkg::req_s pick;
  logic wr_acc;
  logic rd_acc;
  logic take;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01,
    ST_HOLD = 2'b10
  } seq_e;
  seq_e seq_ff;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;

  // ************************************************************
  // External input conditioning
  // ************************************************************
  // The inputs are read straight from their pins, never via the crossbar.
  assign edge_mode[0] = ext_irq_pin_config_ff[irq_ctrl_pkg::CFG_EDGE0];
  assign edge_mode[1] = ext_irq_pin_config_ff[irq_ctrl_pkg::CFG_EDGE1];
  assign ext_active[0] = ~(ext_irq_zero_input ^
    ext_irq_pin_config_ff[irq_ctrl_pkg::CFG_POL0]);
  assign ext_active[1] = ~(ext_irq_one_input ^
    ext_irq_pin_config_ff[irq_ctrl_pkg::CFG_POL1]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_ff <= 2'b00;
    end else begin
      ext_prev_ff <= ext_active;
    end
  end

  // ************************************************************
  // Arbitration
  // ************************************************************
  assign eligible = pend_ff & enable_ff & {16{global_irq_enable_ff}};

  always_comb begin
    pick = '0;
    for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && !prio_ff[i] && !in_low_ff && !in_high_ff) begin
        pick = '{valid: 1'b1, high: 1'b0, index: 4'(i)};
      end
    end
    for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && prio_ff[i] && !in_high_ff) begin
        pick = '{valid: 1'b1, high: 1'b1, index: 4'(i)};
      end
    end
  end

  // Decoding each cycle gives one detect cycle before the call starts.
  assign take = (seq_ff == ST_IDLE) & pick.valid & ~cpu_stall
    & ~hold_ff & ~return_from_interrupt_done;

  // ************************************************************
  // Service sequencing
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_ff <= ST_IDLE;
      irq_req <= 1'b0;
      irq_vector <= 16'h0000;
      irq_index <= 4'h0;
    end else begin
      unique case (seq_ff)
        ST_IDLE: begin
          if (take) begin
            seq_ff <= ST_CALL;
            irq_req <= 1'b1;
            irq_index <= pick.index;
            irq_vector <= irq_ctrl_pkg::VEC_BASE +
              (irq_ctrl_pkg::VEC_STEP * {12'h000, pick.index});
          end
        end
        ST_CALL: begin
          if (call_done) begin
            seq_ff <= ST_IDLE;
            irq_req <= 1'b0;
          end
        end
        ST_HOLD: begin
          seq_ff <= ST_IDLE;
        end
        default: begin
          seq_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Active service levels; a return ends the highest one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_low_ff <= 1'b0;
      in_high_ff <= 1'b0;
    end else if (seq_ff == ST_CALL && call_done) begin
      if (prio_ff[irq_index]) begin
        in_high_ff <= 1'b1;
      end else begin
        in_low_ff <= 1'b1;
      end
    end else if (return_from_interrupt_done) begin
      if (in_high_ff) begin
        in_high_ff <= 1'b0;
      end else begin
        in_low_ff <= 1'b0;
      end
    end
  end

  // After a return one instruction must finish before the next call.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 1'b0;
    end else if (return_from_interrupt_done) begin
      hold_ff <= 1'b1;
    end else if (instr_done) begin
      hold_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Pending flags
  // ************************************************************
  assign sw_set = wr_acc && paddr == irq_ctrl_pkg::OFS_PEND
    ? pwdata[15:0] : 16'h0000;

  always_comb begin
    hw_clr = 16'h0000;
    if (seq_ff == ST_IDLE && take) begin
      hw_clr[pick.index] = (pick.index == 4'(irq_ctrl_pkg::SRC_TMR0)) |
        (pick.index == 4'(irq_ctrl_pkg::SRC_TMR1)) |
        (pick.index == 4'(irq_ctrl_pkg::SRC_EXT0)) |
        (pick.index == 4'(irq_ctrl_pkg::SRC_EXT1));
    end
  end

  generate
    for (genvar g = 0; g < irq_ctrl_pkg::NUM_SRC; g++) begin : g_pend
      if (g == irq_ctrl_pkg::SRC_EXT0 || g == irq_ctrl_pkg::SRC_EXT1) begin
        localparam int unsigned E = (g == irq_ctrl_pkg::SRC_EXT0) ? 0 : 1;
        always_comb begin
          if (!edge_mode[E]) begin
            nxt_pend[g] = ext_active[E];
          end else if (ext_active[E] && !ext_prev_ff[E]) begin
            nxt_pend[g] = 1'b1;
          end else if (sw_set[g]) begin
            nxt_pend[g] = 1'b1;
          end else if (hw_clr[g]) begin
            nxt_pend[g] = 1'b0;
          end else if (wr_acc && paddr == irq_ctrl_pkg::OFS_PEND) begin
            nxt_pend[g] = pwdata[g];
          end else begin
            nxt_pend[g] = pend_ff[g];
          end
        end
      end else begin : g_per
        always_comb begin
          if (src_event[g] || sw_set[g]) begin
            nxt_pend[g] = 1'b1;
          end else if (hw_clr[g]) begin
            nxt_pend[g] = 1'b0;
          end else if (wr_acc && paddr == irq_ctrl_pkg::OFS_PEND) begin
            nxt_pend[g] = pwdata[g];
          end else begin
            nxt_pend[g] = pend_ff[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= irq_ctrl_pkg::RST_PEND;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= irq_ctrl_pkg::RST_ENABLE;
      prio_ff <= irq_ctrl_pkg::RST_PRIO;
      global_irq_enable_ff <= 1'b0;
      ext_irq_pin_config_ff <= irq_ctrl_pkg::RST_EXTCFG;
    end else if (wr_acc) begin
      unique case (paddr)
        irq_ctrl_pkg::OFS_ENABLE: begin
          enable_ff <= pwdata[15:0];
          global_irq_enable_ff <= pwdata[irq_ctrl_pkg::GIE_BIT];
        end
        irq_ctrl_pkg::OFS_PRIO: prio_ff <= pwdata[15:0];
        irq_ctrl_pkg::OFS_EXTCFG: ext_irq_pin_config_ff <= pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      irq_ctrl_pkg::OFS_PEND: nxt_prdata = {16'h0000, pend_ff};
      irq_ctrl_pkg::OFS_ENABLE: begin
        nxt_prdata = {15'h0000, global_irq_enable_ff, enable_ff};
      end
      irq_ctrl_pkg::OFS_PRIO: nxt_prdata = {16'h0000, prio_ff};
      irq_ctrl_pkg::OFS_EXTCFG: nxt_prdata = {28'h000_0000,
        ext_irq_pin_config_ff};
      irq_ctrl_pkg::OFS_TIMER_CONTROL_REG: begin
        nxt_prdata[irq_ctrl_pkg::TIMER_CONTROL_REG_EXT0] =
          pend_ff[irq_ctrl_pkg::SRC_EXT0];
        nxt_prdata[irq_ctrl_pkg::TIMER_CONTROL_REG_EXT1] =
          pend_ff[irq_ctrl_pkg::SRC_EXT1];
      end
      irq_ctrl_pkg::OFS_STATUS: nxt_prdata = {26'h000_0000, in_high_ff,
        in_low_ff, irq_index};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured in setup so every output leaves a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (rd_acc) begin
        prdata <= nxt_prdata;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  vec_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(irq_req) |-> irq_vector ==
      irq_ctrl_pkg::VEC_BASE + 16'(irq_index) * irq_ctrl_pkg::VEC_STEP)
    else $error("Vector does not match source index.");

  no_preempt_a: assert property (@(posedge pclk)
    disable iff (!presetn) in_high_ff && !return_from_interrupt_done |=> !$rose(irq_req))
    else $error("Call issued during high level service.");

  gate_enable_a: assert property (@(posedge pclk)
    disable iff (!presetn) $rose(irq_req) |-> $past(global_irq_enable_ff))
    else $error("Request raised while globally disabled.");

  after_return_from_interrupt_a: assert property (@(posedge pclk)
    disable iff (!presetn) return_from_interrupt_done |=> !irq_req [*1] ##0 hold_ff)
    else $error("Call made right after return.");

  stall_hold_a: assert property (@(posedge pclk)
    disable iff (!presetn) cpu_stall && !irq_req |=> !irq_req)
    else $error("Call started during stall.");

  level_track_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    !edge_mode[0] && !$past(wr_acc) && $stable(edge_mode[0]) |->
      pend_ff[0] == $past(ext_active[0]))
    else $error("Level flag does not follow input.");

  edge_set_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    edge_mode[1] && ext_active[1] && !ext_prev_ff[1] |=> pend_ff[2])
    else $error("Edge did not set pending flag.");

  auto_clr_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    take && pick.index == 4'h1 && !src_event[1] && !sw_set[1]
      |=> !pend_ff[1])
    else $error("Timer flag not cleared on vectoring.");

endmodule : irq_ctrl

`default_nettype wire

// *** cpu_seq_model.sv ***
// Purpose: Behavioural model of the CPU sequencer facing the controller.
// Assumes: Call, return and one following divide take fixed cycle counts.
// Notes: The bench asks for a return by pulsing return_from_interrupt_go for one cycle.
`timescale 1ns/10ps
`default_nettype none

module cpu_seq_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_req,
  input wire logic return_from_interrupt_go,
  output logic call_done,
  output logic return_from_interrupt_done,
  output logic instr_done
);
  logic [3:0] call_cnt_ff;
  logic [4:0] ret_cnt_ff;
  logic call_done_ff, return_from_interrupt_done_ff, instr_done_ff;

  assign call_done = call_done_ff;
  assign return_from_interrupt_done = return_from_interrupt_done_ff;
  assign instr_done = instr_done_ff;

  // The call acknowledge comes after the full call time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_cnt_ff <= 4'h0;
      call_done_ff <= 1'b0;
    end else begin
      call_done_ff <= 1'b0;
      if (irq_req && !call_done_ff) begin
        if (call_cnt_ff == irq_ctrl_pkg::CALL_CYC - 4'h1) begin
          call_done_ff <= 1'b1;
          call_cnt_ff <= 4'h0;
        end else begin
          call_cnt_ff <= call_cnt_ff + 4'h1;
        end
      end
    end
  end

  // A return is always followed by a divide, the slowest next step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ret_cnt_ff <= 5'h00;
      return_from_interrupt_done_ff <= 1'b0;
      instr_done_ff <= 1'b0;
    end else begin
      if (return_from_interrupt_go) begin
        ret_cnt_ff <= 5'h01;
      end else if (ret_cnt_ff != 5'h00) begin
        ret_cnt_ff <= ret_cnt_ff + 5'h01;
      end
      if (ret_cnt_ff ==
        {1'b0, irq_ctrl_pkg::DIV_CYC + irq_ctrl_pkg::RETURN_FROM_INTERRUPT_CYC}) begin
        ret_cnt_ff <= 5'h00;
      end
      return_from_interrupt_done_ff <= (ret_cnt_ff == {1'b0, irq_ctrl_pkg::RETURN_FROM_INTERRUPT_CYC});
      instr_done_ff <= (ret_cnt_ff ==
        {1'b0, irq_ctrl_pkg::DIV_CYC + irq_ctrl_pkg::RETURN_FROM_INTERRUPT_CYC});
    end
  end
endmodule : cpu_seq_model

`default_nettype wire

// *** testbench.sv ***
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: APB answers without wait states; the CPU model paces service.
// Notes: Tests are APB call sequences with fixed expected values.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic pclk, pready, pslverr, irq_req, instr_done, call_done, return_from_interrupt_done;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pin0 = 1'b1, pin1 = 1'b1, cpu_stall = 1'b0, return_from_interrupt_go = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic [15:0] src_event = 16'h0000;
  logic [15:0] irq_vector, ev;
  logic [3:0] irq_index;
  int errors, checks, n, c;

  irq_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .ext_irq_zero_input(pin0),
    .ext_irq_one_input(pin1), .cpu_stall(cpu_stall),
    .instr_done(instr_done), .call_done(call_done), .return_from_interrupt_done(return_from_interrupt_done),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_index(irq_index));
  cpu_seq_model i_cpu (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .return_from_interrupt_go(return_from_interrupt_go), .call_done(call_done), .return_from_interrupt_done(return_from_interrupt_done),
    .instr_done(instr_done));

  // ************************************************************
  // Access and compare tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Each call starts one edge later, so strobes never change twice at once.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    chk("slave error", 32'h0000_0000, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", 32'h0000_0001, {31'h0, t < 50});
  endtask : apb

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdc

  task automatic req_is(input logic [3:0] e);
    c = 0;
    while (irq_req !== 1'b1 && c < 200) begin
      @(posedge pclk);
      c++;
    end
    chk("request", 32'h0000_0001, {31'h0, irq_req});
    chk("index", {28'h0, e}, {28'h0, irq_index});
  endtask : req_is

  task automatic idle_is(input string nm);
    chk(nm, 32'h0000_0000, {31'h0, irq_req});
  endtask : idle_is

  task automatic end_call();
    int t;
    t = 0;
    while (irq_req !== 1'b0 && t < 50) begin
      @(posedge pclk);
      t++;
    end
    idle_is("call ends");
  endtask : end_call

  task automatic ret();
    int t;
    t = 0;
    return_from_interrupt_go <= 1'b1;
    @(posedge pclk);
    return_from_interrupt_go <= 1'b0;
    while (instr_done !== 1'b1 && t < 50) begin
      @(posedge pclk);
      t++;
    end
    chk("return done", 32'h0000_0001, {31'h0, instr_done});
    idle_is("held after return");
  endtask : ret

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ************************************************************
  // Clock, watchdog and tests
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    #50us;
    errors++;
    $display("wrong value watchdog expected finish seen hang");
    stop_test();
  end

  initial begin
    errors = 0;
    checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (n = 0; n < 6; n++) begin
      rdc("reset value", 12'(4 * n), 32'h0000_0000);
    end
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    rdc("unmapped", 12'h020, 32'h0000_0000);
    $display("test reset done");
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    apb(1'b1, irq_ctrl_pkg::OFS_EXTCFG, 32'h0000_000F);
    apb(1'b1, irq_ctrl_pkg::OFS_PEND, 32'h0000_0000);
    apb(1'b1, irq_ctrl_pkg::OFS_ENABLE, 32'h0001_0004);
    pin1 <= 1'b1;
    req_is(4'h2);
    end_call();
    rdc("edge flag", irq_ctrl_pkg::OFS_TIMER_CONTROL_REG, 32'h0000_0000);
    ret();
    repeat (8) @(posedge pclk);
    idle_is("no second edge");
    $display("test edge done");
    apb(1'b1, irq_ctrl_pkg::OFS_ENABLE, 32'h0001_FFFF);
    for (n = 0; n < 16; n++) begin
      apb(1'b1, irq_ctrl_pkg::OFS_PEND, 32'h0000_0001 << n);
      req_is(4'(n));
      chk("latency", 32'h0000_0001, {31'h0, c <= 2});
      ev = irq_ctrl_pkg::VEC_BASE + irq_ctrl_pkg::VEC_STEP * 16'(n);
      chk("vector", {16'h0000, ev}, {16'h0000, irq_vector});
      end_call();
      rdc("clear on call", irq_ctrl_pkg::OFS_PEND,
          (n < 4) ? 32'h0000_0000 : (32'h0000_0001 << n));
      apb(1'b1, irq_ctrl_pkg::OFS_PEND, 32'h0000_0000);
      ret();
    end
    $display("test vectors done");
    apb(1'b1, irq_ctrl_pkg::OFS_PRIO, 32'h0000_0200);
    apb(1'b1, irq_ctrl_pkg::OFS_PEND, 32'h0000_0220);
    req_is(4'h9);
    end_call();
    apb(1'b1, irq_ctrl_pkg::OFS_PEND, 32'h0000_0022);
    repeat (20) @(posedge pclk);
    idle_is("high not preempted");
    ret();
    req_is(4'h1);
    chk("return latency", 32'h0000_0001, {31'h0, c == 2});
    end_call();
    apb(1'b1, irq_ctrl_pkg::OFS_PEND, 32'h0000_0220);
    req_is(4'h9);
    end_call();
    rdc("status", irq_ctrl_pkg::OFS_STATUS, 32'h0000_0039);
    apb(1'b1, irq_ctrl_pkg::OFS_PEND, 32'h0000_0000);
    apb(1'b1, irq_ctrl_pkg::OFS_PRIO, 32'h0000_0000);
    ret();
    ret();
    $display("test priority done");
    apb(1'b1, irq_ctrl_pkg::OFS_ENABLE, 32'h0000_0000);
    apb(1'b1, irq_ctrl_pkg::OFS_EXTCFG, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    rdc("level flags", irq_ctrl_pkg::OFS_TIMER_CONTROL_REG, 32'h0000_0002);
    pin1 <= 1'b0;
    repeat (4) @(posedge pclk);
    rdc("level flags", irq_ctrl_pkg::OFS_TIMER_CONTROL_REG, 32'h0000_000A);
    pin1 <= 1'b1;
    src_event <= 16'h0400;
    @(posedge pclk);
    src_event <= 16'h0000;
    apb(1'b0, irq_ctrl_pkg::OFS_PEND, 32'h0000_0000);
    chk("event flag", 32'h0000_0400, rd & 32'h0000_0400);
    idle_is("masked");
    apb(1'b1, irq_ctrl_pkg::OFS_PEND, 32'h0000_0000);
    cpu_stall <= 1'b1;
    apb(1'b1, irq_ctrl_pkg::OFS_ENABLE, 32'h0001_0001);
    repeat (10) @(posedge pclk);
    idle_is("stalled");
    cpu_stall <= 1'b0;
    req_is(4'h0);
    pin0 <= 1'b1;
    end_call();
    ret();
    repeat (4) @(posedge pclk);
    idle_is("level released");
    apb(1'b1, irq_ctrl_pkg::OFS_ENABLE, 32'h0000_0000);
    apb(1'b1, irq_ctrl_pkg::OFS_EXTCFG, 32'h0000_0006);
    pin1 <= 1'b0;
    repeat (4) @(posedge pclk);
    rdc("mixed modes", irq_ctrl_pkg::OFS_TIMER_CONTROL_REG, 32'h0000_000A);
    $display("test level done");
    stop_test();
  end
endmodule : testbench

`default_nettype wire
